/* hdl/sdaq_pkg.sv */
// constants shared by the serial acquisition command responder
package sdaq_pkg;
    // frame characters
    localparam logic [7:0] SDAQ_START_CHAR  = 8'h21;
    localparam logic [7:0] SDAQ_MODULE_ADDR = 8'h30;
    localparam logic [7:0] SDAQ_CMD_READ    = 8'h52;
    localparam logic [7:0] SDAQ_SEL_ANALOG  = 8'h41;
    localparam logic [7:0] SDAQ_SEL_DIGITAL = 8'h44;
    // digital status byte layout
    localparam int         SDAQ_DOUT_BIT    = 0;
    localparam int         SDAQ_DIN_BIT     = 3;
    // converter
    localparam int         SDAQ_ADC_BITS    = 12;
    localparam int         SDAQ_NUM_CH      = 6;
    localparam int         SDAQ_CH_W        = 8;
    // serial timing
    localparam int         SDAQ_CLK_HZ      = 40_000_000;
    localparam int         SDAQ_BAUD        = 9600;
    localparam int         SDAQ_BIT_CLKS    = SDAQ_CLK_HZ / SDAQ_BAUD;
    localparam int         SDAQ_CNT_W       = 16;
    localparam logic [3:0] SDAQ_FRAME_BITS  = 4'ha;
    localparam logic [3:0] SDAQ_STOP_IDX    = 4'h9;

    typedef enum logic [3:0] {
        SDAQ_ST_IDLE = 4'h0,
        SDAQ_ST_ADDR = 4'h1,
        SDAQ_ST_CMD  = 4'h3,
        SDAQ_ST_SEL  = 4'h2,
        SDAQ_ST_CHAN = 4'h6,
        SDAQ_ST_CONV = 4'h7,
        SDAQ_ST_HI   = 4'h5,
        SDAQ_ST_LO   = 4'h4,
        SDAQ_ST_DIG  = 4'hc
    } sdaq_state_t;
endpackage

/* hdl/sdaq_tx_if.sv */
// byte handshake between the responder and its serial transmitter
`timescale 1ns/1ps
interface sdaq_tx_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hdl/sdaq_uart_tx.sv */
// serial transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
module sdaq_uart_tx
    import sdaq_pkg::*;
#(
    parameter int BIT_CLKS = SDAQ_BIT_CLKS
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    sdaq_tx_if.snk    tx,
    output logic      txd
);
    localparam logic [SDAQ_CNT_W-1:0] BIT_LAST = SDAQ_CNT_W'(BIT_CLKS - 1);

    logic [9:0]            sh_r;
    logic [3:0]            bits_r;
    logic [SDAQ_CNT_W-1:0] cnt_r;
    wire                   busy     = (bits_r != 4'h0);
    wire                   load     = tx.valid && !busy;
    wire                   bit_tick = busy && (cnt_r == BIT_LAST);

    assign tx.ready = !busy;
    // line idles high because the shifter refills with ones
    assign txd      = sh_r[0];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sh_r   <= 10'h3ff;
            bits_r <= 4'h0;
            cnt_r  <= '0;
        end else if (load) begin
            sh_r   <= {1'b1, tx.data, 1'b0};
            bits_r <= SDAQ_FRAME_BITS;
            cnt_r  <= '0;
        end else if (bit_tick) begin
            sh_r   <= {1'b1, sh_r[9:1]};
            bits_r <= bits_r - 4'h1;
            cnt_r  <= '0;
        end else if (busy) begin
            cnt_r  <= cnt_r + 1'b1;
        end
    end

    chk_tx_frame_start: assert property (@(posedge core_clk)
        disable iff (!resetn)
        load |=> !txd && busy)
        else $error("start bit not driven after load");
endmodule

/* hdl/sdaq_responder.sv */
// command responder: serial receive, frame decode, reply sequencing
// What this block does
// - two bytes per channel, upper first
// - data byte names highest channel to convert
// - reply pair equals upper*256 plus lower
// - channels reported descending down to zero
// - digital read has no data, one reply
// - output level bit 0, input bit 3
// - act only on address character zero
// - 8 data bits, no parity, one stop
`timescale 1ns/1ps
module sdaq_responder
    import sdaq_pkg::*;
#(
    parameter int BIT_CLKS = SDAQ_BIT_CLKS,
    parameter int NUM_CH   = SDAQ_NUM_CH
) (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic                     rxd,
    output logic                          txd,
    output logic                          adc_req,
    output logic [SDAQ_CH_W-1:0]          adc_chan,
    input  wire logic                     adc_done,
    input  wire logic [SDAQ_ADC_BITS-1:0] adc_data,
    input  wire logic                     dig_out_level,
    input  wire logic                     dig_in_pin
);
    localparam logic [SDAQ_CNT_W-1:0] BIT_LAST = SDAQ_CNT_W'(BIT_CLKS - 1);
    localparam logic [SDAQ_CNT_W-1:0] HALF_BIT = SDAQ_CNT_W'(BIT_CLKS / 2);
    localparam logic [SDAQ_CH_W-1:0]  CH_MAX   = SDAQ_CH_W'(NUM_CH - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, a change counts once stages two and three agree
    logic [2:0] rx_sync_r;
    logic [2:0] din_sync_r;
    logic       rx_lvl_r;
    logic       din_lvl_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_sync_r  <= 3'h7;
            din_sync_r <= 3'h0;
            rx_lvl_r   <= 1'b1;
            din_lvl_r  <= 1'b0;
        end else begin
            rx_sync_r  <= {rx_sync_r[1:0], rxd};
            din_sync_r <= {din_sync_r[1:0], dig_in_pin};
            if (rx_sync_r[1] == rx_sync_r[2])
                rx_lvl_r <= rx_sync_r[2];
            if (din_sync_r[1] == din_sync_r[2])
                din_lvl_r <= din_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver, samples mid-bit; framing errors drop the character
    logic                  rx_act_r;
    logic [SDAQ_CNT_W-1:0] rx_cnt_r;
    logic [3:0]            rx_bit_r;
    logic [7:0]            rx_sh_r;
    logic                  rx_vld_r;
    logic [7:0]            rx_byte_r;
    wire                   rx_samp   = rx_act_r && (rx_cnt_r == '0);
    wire                   rx_start  = !rx_act_r && !rx_lvl_r;
    wire                   rx_false  = rx_samp && rx_bit_r == 4'h0 && rx_lvl_r;
    wire                   rx_stop   = rx_samp && rx_bit_r == SDAQ_STOP_IDX;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_act_r  <= 1'b0;
            rx_cnt_r  <= '0;
            rx_bit_r  <= 4'h0;
            rx_sh_r   <= 8'h00;
            rx_vld_r  <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_vld_r <= rx_stop && rx_lvl_r;
            if (rx_stop && rx_lvl_r)
                rx_byte_r <= rx_sh_r;
            if (rx_start) begin
                rx_act_r <= 1'b1;
                rx_cnt_r <= HALF_BIT;
                rx_bit_r <= 4'h0;
            end else if (rx_false || rx_stop) begin
                rx_act_r <= 1'b0;
            end else if (rx_samp) begin
                rx_cnt_r <= BIT_LAST;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r != 4'h0)
                    rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
            end else if (rx_act_r) begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame decode and reply sequencing
    sdaq_tx_if tx_if ();

    sdaq_uart_tx #(
        .BIT_CLKS (BIT_CLKS)
    ) u_tx (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tx       (tx_if),
        .txd      (txd)
    );

    sdaq_state_t              st_r;
    sdaq_state_t              st_nxt;
    logic [SDAQ_CH_W-1:0]     ch_r;
    logic [SDAQ_ADC_BITS-1:0] res_r;
    logic                     adc_req_r;

    wire       tx_acc    = tx_if.valid && tx_if.ready;
    // a stray byte mid-frame restarts on a start character
    wire sdaq_state_t resync =
        (rx_byte_r == SDAQ_START_CHAR) ? SDAQ_ST_ADDR : SDAQ_ST_IDLE;
    wire       ch_ok     = (rx_byte_r <= CH_MAX);
    wire [7:0] hi_byte   = 8'(res_r >> 8);
    wire [7:0] lo_byte   = res_r[7:0];
    wire [7:0] dig_byte  = (8'(din_lvl_r) << SDAQ_DIN_BIT) |
                           (8'(dig_out_level) << SDAQ_DOUT_BIT);

    assign tx_if.valid = (st_r == SDAQ_ST_HI) || (st_r == SDAQ_ST_LO) ||
                         (st_r == SDAQ_ST_DIG);
    assign tx_if.data  = (st_r == SDAQ_ST_HI) ? hi_byte :
                         (st_r == SDAQ_ST_LO) ? lo_byte :
                         dig_byte;
    assign adc_req     = adc_req_r;
    assign adc_chan    = ch_r;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            SDAQ_ST_IDLE:
                if (rx_vld_r && rx_byte_r == SDAQ_START_CHAR)
                    st_nxt = SDAQ_ST_ADDR;
            SDAQ_ST_ADDR:
                if (rx_vld_r)
                    st_nxt = (rx_byte_r == SDAQ_MODULE_ADDR) ?
                             SDAQ_ST_CMD : resync;
            SDAQ_ST_CMD:
                if (rx_vld_r)
                    st_nxt = (rx_byte_r == SDAQ_CMD_READ) ?
                             SDAQ_ST_SEL : resync;
            SDAQ_ST_SEL:
                if (rx_vld_r) begin
                    if (rx_byte_r == SDAQ_SEL_ANALOG)
                        st_nxt = SDAQ_ST_CHAN;
                    else if (rx_byte_r == SDAQ_SEL_DIGITAL)
                        st_nxt = SDAQ_ST_DIG;
                    else
                        st_nxt = resync;
                end
            // raw channel byte may equal the start character
            SDAQ_ST_CHAN:
                if (rx_vld_r)
                    st_nxt = ch_ok ? SDAQ_ST_CONV : SDAQ_ST_IDLE;
            SDAQ_ST_CONV:
                if (adc_done)
                    st_nxt = SDAQ_ST_HI;
            SDAQ_ST_HI:
                if (tx_acc)
                    st_nxt = SDAQ_ST_LO;
            SDAQ_ST_LO:
                if (tx_acc)
                    st_nxt = (ch_r == '0) ?
                             SDAQ_ST_IDLE : SDAQ_ST_CONV;
            SDAQ_ST_DIG:
                if (tx_acc)
                    st_nxt = SDAQ_ST_IDLE;
            default:
                st_nxt = SDAQ_ST_IDLE;
        endcase
    end

    // bytes arriving while a reply runs are dropped, no queue
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r      <= SDAQ_ST_IDLE;
            ch_r      <= '0;
            res_r     <= '0;
            adc_req_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            adc_req_r <= st_nxt == SDAQ_ST_CONV && st_r != SDAQ_ST_CONV;
            if (st_r == SDAQ_ST_CHAN && rx_vld_r)
                ch_r <= rx_byte_r;
            else if (st_r == SDAQ_ST_LO && tx_acc && ch_r != '0)
                ch_r <= ch_r - 1'b1;
            if (st_r == SDAQ_ST_CONV && adc_done)
                res_r <= adc_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hi_sent;
        st_r == SDAQ_ST_HI && tx_acc;
    endsequence

    sequence s_lo_sent;
        st_r == SDAQ_ST_LO && tx_acc;
    endsequence

    // upper byte as it left, the pair check needs both wire values
    logic [7:0] hi_sent_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            hi_sent_r <= 8'h00;
        else if (st_r == SDAQ_ST_HI && tx_acc)
            hi_sent_r <= tx_if.data;
    end

    chk_upper_then_lower: assert property (@(posedge core_clk)
        disable iff (!resetn)
        s_hi_sent |=> st_r == SDAQ_ST_LO && tx_if.valid &&
                      tx_if.data == $past(res_r[7:0]))
        else $error("lower byte did not follow upper byte");

    chk_pair_value: assert property (@(posedge core_clk)
        disable iff (!resetn)
        s_lo_sent |-> {hi_sent_r, tx_if.data} == 16'(res_r))
        else $error("reply pair does not equal conversion result");

    chk_chan_request: assert property (@(posedge core_clk)
        disable iff (!resetn)
        st_r == SDAQ_ST_CHAN && rx_vld_r && ch_ok |=>
        adc_req && adc_chan == $past(rx_byte_r))
        else $error("requested channel not converted");

    chk_chan_descend: assert property (@(posedge core_clk)
        disable iff (!resetn)
        s_lo_sent ##0 (ch_r != '0) |=>
        adc_req && adc_chan == $past(ch_r) - 1'b1)
        else $error("channels not reported in descending order");

    chk_last_chan: assert property (@(posedge core_clk)
        disable iff (!resetn)
        s_lo_sent ##0 (ch_r == '0) |=> st_r == SDAQ_ST_IDLE)
        else $error("reply continued past channel zero");

    chk_dig_layout: assert property (@(posedge core_clk)
        disable iff (!resetn)
        st_r == SDAQ_ST_DIG |->
        tx_if.data[SDAQ_DOUT_BIT] == dig_out_level &&
        tx_if.data[SDAQ_DIN_BIT] == din_lvl_r &&
        (tx_if.data & 8'hf6) == 8'h00)
        else $error("digital status byte misplaced");

    chk_dig_single: assert property (@(posedge core_clk)
        disable iff (!resetn)
        st_r == SDAQ_ST_DIG && tx_acc |=> !tx_if.valid [*2])
        else $error("digital read sent more than one byte");

    chk_addr_gate: assert property (@(posedge core_clk)
        disable iff (!resetn)
        st_r == SDAQ_ST_ADDR && rx_vld_r &&
        rx_byte_r != SDAQ_MODULE_ADDR |=> st_r != SDAQ_ST_CMD)
        else $error("frame for another address accepted");

    chk_bad_resync: assert property (@(posedge core_clk)
        disable iff (!resetn)
        st_r == SDAQ_ST_SEL && rx_vld_r &&
        rx_byte_r != SDAQ_SEL_ANALOG && rx_byte_r != SDAQ_SEL_DIGITAL |=>
        !tx_if.valid && st_r == $past(resync))
        else $error("unknown command not discarded");
endmodule

/* bench/sdaq_host.sv */
// host serial port model: sends command characters, collects reply bytes
`timescale 1ns/1ps
module sdaq_host #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic core_clk,
    input  wire logic txd,
    output logic      rxd
);
    // line idles at mark level between characters
    initial rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // start bit, 8 data bits lsb first, no parity, one stop bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge core_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // ok only for a whole character with a good stop bit
    task automatic recv(output logic [7:0] b, output bit ok,
                        input int wait_max);
        int n;
        ok = 1'b0;
        b  = 8'h00;
        n  = 0;
        while (n < wait_max && txd !== 1'b0) begin
            @(posedge core_clk);
            n++;
        end
        if (n < wait_max) begin
            // mid-bit sampling keeps clear of edge races
            repeat (BIT_CLKS / 2) @(posedge core_clk);
            if (txd === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CLKS) @(posedge core_clk);
                    b[i] = txd;
                end
                repeat (BIT_CLKS) @(posedge core_clk);
                ok = (txd === 1'b1);
            end
        end
    endtask
endmodule

/* bench/serial_daq_command_responder_tb.sv */
// testbench of the command responder, host model on the serial pins
`timescale 1ns/1ps
module serial_daq_command_responder_tb;
    import sdaq_pkg::*;
    localparam int BC = 16;
    logic                     core_clk;
    logic                     resetn;
    logic                     rxd;
    logic                     txd;
    logic                     adc_req;
    logic [SDAQ_CH_W-1:0]     adc_chan;
    logic                     adc_done;
    logic [SDAQ_ADC_BITS-1:0] adc_data;
    logic                     dig_out_level;
    logic                     dig_in_pin;
    int                       n_errors;
    int                       n_tests;
    int                       cycles;

    sdaq_responder #(.BIT_CLKS(BC), .NUM_CH(6)) sdaq_responder_i (
        .core_clk(core_clk), .resetn(resetn), .rxd(rxd), .txd(txd),
        .adc_req(adc_req), .adc_chan(adc_chan), .adc_done(adc_done),
        .adc_data(adc_data), .dig_out_level(dig_out_level),
        .dig_in_pin(dig_in_pin));
    sdaq_host #(.BIT_CLKS(BC)) sdaq_host_i (
        .core_clk(core_clk), .txd(txd), .rxd(rxd));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // channel 0 gives full scale, others a pattern with a nonzero top nibble
    function automatic logic [11:0] adc_val(input logic [7:0] c);
        return (c == 8'h00) ? 12'hfff : {c[3:0], 8'ha5 ^ c};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // converter: answers one cycle after a request, scrambles data otherwise
    always @(posedge core_clk) begin
        if (!resetn) begin
            adc_done <= 1'b0;
            adc_data <= 12'h000;
        end else begin
            adc_done <= adc_req;
            adc_data <= adc_req ? adc_val(adc_chan) : ~adc_data;
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic expect_byte(input logic [7:0] exp);
        logic [7:0] b;
        bit         ok;
        sdaq_host_i.recv(b, ok, 3000);
        n_tests++;
        if (!ok || b !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, b, exp);
        end
    endtask

    // no start bit may appear for a full three character times
    task automatic expect_none();
        logic [7:0] b;
        bit         ok;
        sdaq_host_i.recv(b, ok, 30 * BC);
        n_tests++;
        if (txd !== 1'b1 || ok) begin
            n_errors++;
            $display("CHECK FAILED at %0t: unexpected reply", $time);
        end
    endtask

    // start, address, read letter, selector, optional channel
    task automatic frame(input logic [7:0] addr, sel, chan, input bit wc);
        sdaq_host_i.send(SDAQ_START_CHAR);
        sdaq_host_i.send(addr);
        sdaq_host_i.send(SDAQ_CMD_READ);
        sdaq_host_i.send(sel);
        if (wc)
            sdaq_host_i.send(chan);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_analog();
        logic [11:0] v;
        frame(SDAQ_MODULE_ADDR, SDAQ_SEL_ANALOG, 8'h02, 1'b1);
        for (int c = 2; c >= 0; c--) begin
            v = adc_val(8'(c));
            expect_byte({4'h0, v[11:8]});
            expect_byte(v[7:0]);
        end
        expect_none();
    endtask

    task automatic t_digital();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            dig_out_level <= i[0];
            dig_in_pin    <= i[1];
            frame(SDAQ_MODULE_ADDR, SDAQ_SEL_DIGITAL, 8'h00, 1'b0);
            expect_byte({4'h0, i[1], 2'b00, i[0]});
        end
        expect_none();
    endtask

    // wrong address, channel past the last one, unknown selector,
    // then a broken frame
    task automatic t_refuse();
        frame(8'h31, SDAQ_SEL_DIGITAL, 8'h00, 1'b0);
        expect_none();
        frame(SDAQ_MODULE_ADDR, SDAQ_SEL_ANALOG, 8'h06, 1'b1);
        expect_none();
        frame(SDAQ_MODULE_ADDR, 8'h58, 8'h00, 1'b0);
        expect_none();
        sdaq_host_i.send(SDAQ_START_CHAR);
        sdaq_host_i.send(SDAQ_MODULE_ADDR);
        frame(SDAQ_MODULE_ADDR, SDAQ_SEL_DIGITAL, 8'h00, 1'b0);
        expect_byte({4'h0, dig_in_pin, 2'b00, dig_out_level});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors      = 0;
        n_tests       = 0;
        resetn        = 1'b0;
        dig_out_level = 1'b0;
        dig_in_pin    = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        // give the input synchronisers time to settle
        repeat (8) @(posedge core_clk);
        t_analog();
        t_digital();
        t_refuse();
        results();
    end
endmodule
